// ==== shared/clkout_pkg.sv ====
package clkout_pkg;
    // Register indices on the management bus
    localparam logic [7:0] OFS_BUF_EN     = 8'h02;
    localparam logic [7:0] OFS_OUT_CTRL   = 8'h03;
    localparam logic [7:0] OFS_DIV_HIGH   = 8'h04;
    localparam logic [7:0] OFS_DIV_LOW    = 8'h05;
    localparam logic [7:0] OFS_RSVD_SIX   = 8'h06;
    localparam logic [7:0] OFS_RSVD_SEVEN = 8'h07;
    localparam logic [7:0] OFS_RSVD_EIGHT = 8'h08;
    // Reset values
    localparam logic [7:0] RST_BUF_EN     = 8'hFF;
    localparam logic [7:0] RST_OUT_CTRL   = 8'h30;
    localparam logic [7:0] RST_DIV_HIGH   = 8'hCC;
    localparam logic [7:0] RST_DIV_LOW    = 8'h64;
    localparam logic [7:0] RST_RSVD_SIX   = 8'hC1;
    localparam logic [7:0] RST_RSVD_SEVEN = 8'h00;
    localparam logic [7:0] RST_RSVD_EIGHT = 8'h00;
    // Field positions
    localparam int POS_PROC_EN0   = 7;
    localparam int POS_SERIAL_EN0 = 4;
    localparam int POS_DISPLAY_EN = 1;
    localparam int POS_PANEL_EN   = 0;
    localparam int POS_REF_EN     = 5;
    localparam int POS_SLEW_LO    = 3;
    localparam int POS_STOP0      = 2;
    localparam int POS_DIV_MSB    = 0;
    // Writable masks; other bits keep reset values
    localparam logic [7:0] MASK_OUT_CTRL = 8'h3F;
    localparam logic [7:0] MASK_DIV_HIGH = 8'h01;
    localparam logic [1:0] SLEW_RESERVED = 2'h3;
    // Management bus addressing
    localparam logic [6:0] BUS_ADDR7  = 7'h69;
    localparam logic [7:0] READ_COUNT = 8'h0F;
    localparam int PAIRS = 3;
endpackage

// ==== shared/reg_access_if.sv ====
`timescale 1ns/1ps
interface reg_access_if;
    logic       wrStb;   // One-cycle write strobe
    logic [7:0] addr;    // Register index
    logic [7:0] wrData;  // Write byte
    logic [7:0] rdData;  // Read byte for addr
    modport master (output wrStb, output addr, output wrData, input rdData);
    modport bank   (input wrStb, input addr, input wrData, output rdData);
endinterface

// ==== design/clkout_reg_bank.sv ====
`timescale 1ns/1ps
module clkout_reg_bank (
    input  wire logic       clk,      // System clock
    input  wire logic       rstn,     // Async reset, low
    input  wire logic       ce,       // Clock enable
    reg_access_if.bank      bus,      // Register access
    output logic [7:0]      bufEnQ,   // Output buffer enables
    output logic [7:0]      ctrlQ,    // Output control
    output logic [7:0]      divHighQ, // Divider high byte
    output logic [7:0]      divLowQ   // Divider low byte
);
    logic [7:0] bufEnD;   // Next buffer enables
    logic [7:0] ctrlD;    // Next control
    logic [7:0] divHighD; // Next divider high
    logic [7:0] divLowD;  // Next divider low

    // Read decode by index
    function automatic logic [7:0] readByte(input logic [7:0] a, input logic [7:0] b,
                                            input logic [7:0] c, input logic [7:0] h,
                                            input logic [7:0] l);
        case (a)
            clkout_pkg::OFS_BUF_EN:     readByte = b;
            clkout_pkg::OFS_OUT_CTRL:   readByte = c;
            clkout_pkg::OFS_DIV_HIGH:   readByte = h;
            clkout_pkg::OFS_DIV_LOW:    readByte = l;
            clkout_pkg::OFS_RSVD_SIX:   readByte = clkout_pkg::RST_RSVD_SIX;
            clkout_pkg::OFS_RSVD_SEVEN: readByte = clkout_pkg::RST_RSVD_SEVEN;
            clkout_pkg::OFS_RSVD_EIGHT: readByte = clkout_pkg::RST_RSVD_EIGHT;
            default:                    readByte = 8'h00;
        endcase
    endfunction

    assign bus.rdData = readByte(bus.addr, bufEnQ, ctrlQ, divHighQ, divLowQ);

    // Write decode
    always_comb begin
        bufEnD   = bufEnQ;
        ctrlD    = ctrlQ;
        divHighD = divHighQ;
        divLowD  = divLowQ;
        if (bus.wrStb) begin
            case (bus.addr)
                clkout_pkg::OFS_BUF_EN: begin
                    bufEnD = bus.wrData;
                end
                clkout_pkg::OFS_OUT_CTRL: begin
                    // Reserved bits kept; reserved slew code keeps old slew
                    ctrlD = (bus.wrData & clkout_pkg::MASK_OUT_CTRL)
                          | (ctrlQ & ~clkout_pkg::MASK_OUT_CTRL);
                    if (bus.wrData[clkout_pkg::POS_SLEW_LO +: 2] == clkout_pkg::SLEW_RESERVED) begin
                        ctrlD[clkout_pkg::POS_SLEW_LO +: 2] =
                            ctrlQ[clkout_pkg::POS_SLEW_LO +: 2];
                    end
                end
                clkout_pkg::OFS_DIV_HIGH: begin
                    divHighD = (bus.wrData & clkout_pkg::MASK_DIV_HIGH)
                             | (divHighQ & ~clkout_pkg::MASK_DIV_HIGH);
                end
                clkout_pkg::OFS_DIV_LOW: begin
                    divLowD = bus.wrData;
                end
                default: begin
                    bufEnD = bufEnQ; // Reserved or foreign index: ignored
                end
            endcase
        end
    end

    // Register storage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bufEnQ   <= clkout_pkg::RST_BUF_EN;
            ctrlQ    <= clkout_pkg::RST_OUT_CTRL;
            divHighQ <= clkout_pkg::RST_DIV_HIGH;
            divLowQ  <= clkout_pkg::RST_DIV_LOW;
        end else if (ce) begin
            bufEnQ   <= bufEnD;
            ctrlQ    <= ctrlD;
            divHighQ <= divHighD;
            divLowQ  <= divLowD;
        end
    end
endmodule

// ==== design/clkout_stop_gate.sv ====
`timescale 1ns/1ps
module clkout_stop_gate #(
    parameter int PAIRS = clkout_pkg::PAIRS // Processor pair count
) (
    input  wire logic             clk,           // System clock
    input  wire logic             rstn,          // Async reset, low
    input  wire logic             ce,            // Clock enable
    input  wire logic [7:0]       bufEn,         // Buffer enable byte
    input  wire logic [7:0]       ctrl,          // Control byte
    input  wire logic             procHaltN,     // Processor stop, low
    output logic [PAIRS-1:0]      procPairEnQ,   // Processor pair enables
    output logic [PAIRS-1:0]      serialRefEnQ,  // Serial reference enables
    output logic                  displayEnQ,    // Display 96M enable
    output logic                  panelEnQ,      // Panel pair enable
    output logic                  refEnQ         // Reference enable
);
    logic [PAIRS-1:0] procPairEnD;  // Next processor enables
    logic [PAIRS-1:0] serialRefEnD; // Next serial enables

    // Per-pair gating, bit order descends from pair 0
    for (genvar i = 0; i < PAIRS; i++) begin : g_pair
        always_comb begin
            procPairEnD[i] = bufEn[clkout_pkg::POS_PROC_EN0 - i]
                           & ~(ctrl[clkout_pkg::POS_STOP0 - i] & ~procHaltN);
            serialRefEnD[i] = bufEn[clkout_pkg::POS_SERIAL_EN0 - i];
        end
    end

    // Output enable registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            procPairEnQ  <= '1;
            serialRefEnQ <= '1;
            displayEnQ   <= 1'b1;
            panelEnQ     <= 1'b1;
            refEnQ       <= 1'b1;
        end else if (ce) begin
            procPairEnQ  <= procPairEnD;
            serialRefEnQ <= serialRefEnD;
            displayEnQ   <= bufEn[clkout_pkg::POS_DISPLAY_EN];
            panelEnQ     <= bufEn[clkout_pkg::POS_PANEL_EN];
            refEnQ       <= ctrl[clkout_pkg::POS_REF_EN];
        end
    end
endmodule

// ==== design/clock_output_control_regs.sv ====
`timescale 1ns/1ps
module clock_output_control_regs (
    input  wire logic        clk,          // 25 MHz clock
    input  wire logic        rstn,         // Async reset, low
    input  wire logic        ce,           // Clock enable
    input  wire logic        sclIn,        // Bus clock level
    input  wire logic        sdaIn,        // Bus data level
    output logic             sdaOutQ,      // Bus data drive value
    output logic             sdaOeNQ,      // Bus data enable, low drives
    input  wire logic        procHaltN,    // Processor stop, low
    output logic [2:0]       procPairEn,   // Processor pair enables
    output logic [2:0]       serialRefEn,  // Serial reference enables
    output logic             displayEn,    // Display 96M enable
    output logic             panelEn,      // Panel pair enable
    output logic             refEn,        // Reference enable
    output logic [1:0]       refSlewQ,     // Reference edge rate code
    output logic [8:0]       feedbackDivQ  // Processor PLL feedback divider
);
    // Bus engine states
    typedef enum {
        ST_IDLE,
        ST_RX_BIT,
        ST_RX_ACK,
        ST_TX_BIT,
        ST_TX_ACK
    } bus_state_e;

    // Role of the byte being received
    typedef enum {
        ROLE_ADDR,
        ROLE_INDEX,
        ROLE_COUNT,
        ROLE_DATA
    } byte_role_e;

    reg_access_if regBus ();        // Engine to bank link

    bus_state_e stateQ, stateD;     // Engine state
    byte_role_e roleQ, roleD;       // Current byte role
    logic       sclQ;               // Previous bus clock
    logic       sdaQ;               // Previous bus data
    logic [7:0] shiftQ, shiftD;     // Shift register
    logic [3:0] bitCntQ, bitCntD;   // Bit counter
    logic [7:0] idxQ, idxD;         // Register index pointer
    logic       readQ, readD;       // Read transfer flag
    logic       drvQ, drvD;         // Pull data low
    logic       ackOkQ, ackOkD;     // Host acknowledged
    logic       wrStb;              // Register write strobe
    logic       startCond;          // Start or repeated start
    logic       stopCond;           // Stop
    logic       sclRise;            // Bus clock rising
    logic       sclFall;            // Bus clock falling
    logic [7:0] bufEn;              // Buffer enable byte
    logic [7:0] ctrl;               // Control byte
    logic [7:0] divHigh;            // Divider high byte
    logic [7:0] divLow;             // Divider low byte

    // Bus conditions from sampled levels
    assign startCond = sclIn & sclQ & sdaQ & ~sdaIn;
    assign stopCond  = sclIn & sclQ & ~sdaQ & sdaIn;
    assign sclRise   = sclIn & ~sclQ;
    assign sclFall   = ~sclIn & sclQ;

    // Register port
    assign regBus.wrStb  = wrStb;
    assign regBus.addr   = idxQ;
    assign regBus.wrData = shiftQ;

    // Engine next state
    always_comb begin
        stateD  = stateQ;
        roleD   = roleQ;
        shiftD  = shiftQ;
        bitCntD = bitCntQ;
        idxD    = idxQ;
        readD   = readQ;
        drvD    = drvQ;
        ackOkD  = ackOkQ;
        wrStb   = 1'b0;
        if (startCond) begin
            // New transfer always begins with the address byte
            stateD  = ST_RX_BIT;
            roleD   = ROLE_ADDR;
            bitCntD = 4'h0;
            drvD    = 1'b0;
        end else if (stopCond) begin
            // Stop releases the line
            stateD = ST_IDLE;
            drvD   = 1'b0;
        end else begin
            case (stateQ)
                ST_IDLE: begin
                    drvD = 1'b0; // Line released
                end
                ST_RX_BIT: begin
                    if (sclRise) begin
                        // Sample data on rising clock
                        shiftD  = {shiftQ[6:0], sdaIn};
                        bitCntD = bitCntQ + 4'h1;
                    end else if (sclFall && bitCntQ == 4'h8) begin
                        bitCntD = 4'h0;
                        case (roleQ)
                            ROLE_ADDR: begin
                                if (shiftQ[7:1] == clkout_pkg::BUS_ADDR7) begin
                                    // D2h writes, D3h reads
                                    readD  = shiftQ[0];
                                    drvD   = 1'b1;
                                    stateD = ST_RX_ACK;
                                end else begin
                                    stateD = ST_IDLE; // Not ours
                                end
                            end
                            ROLE_INDEX: begin
                                idxD   = shiftQ;
                                drvD   = 1'b1;
                                stateD = ST_RX_ACK;
                            end
                            ROLE_COUNT: begin
                                drvD   = 1'b1; // Count byte acknowledged only
                                stateD = ST_RX_ACK;
                            end
                            default: begin
                                // Data byte written at pointer
                                wrStb  = 1'b1;
                                idxD   = idxQ + 8'h01;
                                drvD   = 1'b1;
                                stateD = ST_RX_ACK;
                            end
                        endcase
                    end
                end
                ST_RX_ACK: begin
                    if (sclFall) begin
                        drvD = 1'b0;
                        if (roleQ == ROLE_ADDR && readQ) begin
                            // Read begins with the byte count
                            shiftD  = clkout_pkg::READ_COUNT;
                            drvD    = ~clkout_pkg::READ_COUNT[7];
                            bitCntD = 4'h0;
                            stateD  = ST_TX_BIT;
                        end else begin
                            case (roleQ)
                                ROLE_ADDR:  roleD = ROLE_INDEX;
                                ROLE_INDEX: roleD = ROLE_COUNT;
                                default:    roleD = ROLE_DATA;
                            endcase
                            stateD = ST_RX_BIT;
                        end
                    end
                end
                ST_TX_BIT: begin
                    if (sclFall) begin
                        bitCntD = bitCntQ + 4'h1;
                        if (bitCntQ == 4'h7) begin
                            drvD   = 1'b0; // Release for host ack
                            stateD = ST_TX_ACK;
                        end else begin
                            shiftD = {shiftQ[6:0], 1'b0};
                            drvD   = ~shiftQ[6];
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (sclRise) begin
                        ackOkD = ~sdaIn; // Low means acknowledge
                    end else if (sclFall) begin
                        if (ackOkQ) begin
                            // Next byte from pointer
                            shiftD  = regBus.rdData;
                            drvD    = ~regBus.rdData[7];
                            idxD    = idxQ + 8'h01;
                            bitCntD = 4'h0;
                            stateD  = ST_TX_BIT;
                        end else begin
                            stateD = ST_IDLE; // Host ended the read
                        end
                    end
                end
                default: begin
                    stateD = ST_IDLE;
                    drvD   = 1'b0;
                end
            endcase
        end
    end

    // Engine registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stateQ  <= ST_IDLE;
            roleQ   <= ROLE_ADDR;
            sclQ    <= 1'b1;
            sdaQ    <= 1'b1;
            shiftQ  <= 8'h00;
            bitCntQ <= 4'h0;
            idxQ    <= 8'h00;
            readQ   <= 1'b0;
            drvQ    <= 1'b0;
            ackOkQ  <= 1'b0;
        end else if (ce) begin
            stateQ  <= stateD;
            roleQ   <= roleD;
            sclQ    <= sclIn;
            sdaQ    <= sdaIn;
            shiftQ  <= shiftD;
            bitCntQ <= bitCntD;
            idxQ    <= idxD;
            readQ   <= readD;
            drvQ    <= drvD;
            ackOkQ  <= ackOkD;
        end
    end

    // Open-drain pin: value always low, enable low while pulling
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sdaOutQ <= 1'b0;
            sdaOeNQ <= 1'b1;
        end else if (ce) begin
            sdaOutQ <= 1'b0;
            sdaOeNQ <= ~drvD;
        end
    end

    // Field outputs from the bank
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            refSlewQ     <= clkout_pkg::RST_OUT_CTRL[clkout_pkg::POS_SLEW_LO +: 2];
            feedbackDivQ <= {clkout_pkg::RST_DIV_HIGH[clkout_pkg::POS_DIV_MSB],
                             clkout_pkg::RST_DIV_LOW};
        end else if (ce) begin
            refSlewQ     <= ctrl[clkout_pkg::POS_SLEW_LO +: 2];
            feedbackDivQ <= {divHigh[clkout_pkg::POS_DIV_MSB], divLow};
        end
    end

    // Register storage
    clkout_reg_bank u_bank (
        .clk      (clk),
        .rstn     (rstn),
        .ce       (ce),
        .bus      (regBus.bank),
        .bufEnQ   (bufEn),
        .ctrlQ    (ctrl),
        .divHighQ (divHigh),
        .divLowQ  (divLow)
    );

    // Output enable gating
    clkout_stop_gate #(
        .PAIRS (clkout_pkg::PAIRS)
    ) u_gate (
        .clk          (clk),
        .rstn         (rstn),
        .ce           (ce),
        .bufEn        (bufEn),
        .ctrl         (ctrl),
        .procHaltN    (procHaltN),
        .procPairEnQ  (procPairEn),
        .serialRefEnQ (serialRefEn),
        .displayEnQ   (displayEn),
        .panelEnQ     (panelEn),
        .refEnQ       (refEn)
    );
endmodule

// ==== test/clock_output_control_regs_checker.sv ====
`timescale 1ns/1ps
module clock_output_control_regs_checker (
    input wire logic       clk,          // Clock
    input wire logic       rstn,         // Reset, low
    input wire logic       ce,           // Clock enable
    input wire logic       sclIn,        // Bus clock
    input wire logic       sdaOutQ,      // Data drive value
    input wire logic       sdaOeNQ,      // Data enable, low
    input wire logic       procHaltN,    // Stop input, low
    input wire logic [2:0] procPairEn,   // Processor pairs
    input wire logic [2:0] serialRefEn,  // Serial pairs
    input wire logic       displayEn,    // Display pair
    input wire logic       panelEn,      // Panel pair
    input wire logic       refEn,        // Reference output
    input wire logic [1:0] refSlewQ,     // Edge rate
    input wire logic [8:0] feedbackDivQ  // Divider
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Bus clock held high, so no byte can land
    sequence quietBus;
        (sclIn && ce)[*8];
    endsequence
    // Open drain never drives high
    a_drive_value_zero: assert property (!sdaOutQ)
        else $error("data drive value not zero");
    // Device moves data only while bus clock is low
    a_ack_in_low: assert property ($changed(sdaOeNQ) |-> !sclIn)
        else $error("data enable moved with bus clock high");
    a_slew_code_legal: assert property (refSlewQ != 2'h3)
        else $error("reserved edge rate code");
    a_reset_enables: assert property ($rose(rstn) |-> {procPairEn, serialRefEn, displayEn, panelEn,
        refEn, refSlewQ, feedbackDivQ} == {3'h7, 3'h7, 3'h7, 2'h2, 9'h064})
        else $error("outputs not at reset values");
    a_quiet_fields_hold: assert property (quietBus |=> $stable({serialRefEn, displayEn,
        panelEn, refEn, refSlewQ, feedbackDivQ}))
        else $error("field moved without bus traffic");
    a_halt_steady_pairs: assert property (quietBus ##0 $stable(procHaltN) |=> $stable(procPairEn))
        else $error("processor pairs moved with steady stop");
    a_halt_only_stops: assert property (quietBus ##0 !procHaltN |=>
        (procPairEn & ~$past(procPairEn)) == 3'h0)
        else $error("pair enabled while stop asserted");
    a_release_only_starts: assert property (quietBus ##0 procHaltN |=>
        (~procPairEn & $past(procPairEn)) == 3'h0)
        else $error("pair disabled while stop released");
    a_freeze_on_ce: assert property (!ce |=> $stable({procPairEn, serialRefEn, refSlewQ}))
        else $error("outputs moved with clock enable low");
endmodule
bind clock_output_control_regs clock_output_control_regs_checker chk (.clk(clk), .rstn(rstn),
    .ce(ce), .sclIn(sclIn), .sdaOutQ(sdaOutQ), .sdaOeNQ(sdaOeNQ), .procHaltN(procHaltN),
    .procPairEn(procPairEn), .serialRefEn(serialRefEn), .displayEn(displayEn),
    .panelEn(panelEn), .refEn(refEn), .refSlewQ(refSlewQ), .feedbackDivQ(feedbackDivQ));

// ==== test/smbus_host_model.sv ====
`timescale 1ns/1ps
module smbus_host_model (
    input  wire logic clk,    // Clock
    input  wire logic sda,    // Resolved data wire
    output logic      scl,    // Bus clock, idles high
    output logic      sdaOeN  // Low pulls data low
);
    initial begin
        scl = 1'b1;
        sdaOeN = 1'b1;
    end
    // Third of a bit time
    task automatic w();
        repeat (4) @(posedge clk);
    endtask
    // One bit; data settles in clock low phase
    task automatic bitX(input logic b, output logic r);
        w();
        sdaOeN <= b;
        w();
        scl <= 1'b1;
        w();
        r = sda;
        scl <= 1'b0;
    endtask
    // Start or repeated start
    task automatic start();
        w();
        sdaOeN <= 1'b1;
        w();
        scl <= 1'b1;
        w();
        sdaOeN <= 1'b0;
        w();
        scl <= 1'b0;
    endtask
    task automatic stop();
        w();
        sdaOeN <= 1'b0;
        w();
        scl <= 1'b1;
        w();
        sdaOeN <= 1'b1;
        w();
    endtask
    // Byte out and in, MSB first, then acknowledge bit
    task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
                        output logic ack);
        for (int i = 7; i >= 0; i--) bitX(d[i], q[i]);
        bitX(ai, ack);
    endtask
endmodule

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb;
    logic        clk, rstn, ce, procHaltN, scl, hostOeN, sdaOutQ, sdaOeNQ;
    logic [2:0]  procPairEn, serialRefEn;
    logic        displayEn, panelEn, refEn;
    logic [1:0]  refSlewQ;
    logic [8:0]  feedbackDivQ;
    logic [7:0]  bank [2:8];  // Expected register bytes
    logic [7:0]  cornerA [5] = '{8'h03, 8'h04, 8'h02, 8'h06, 8'h03};
    logic [7:0]  cornerD [5] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h07};
    int          mismatches, compares, seed;
    wire         sda = (sdaOeNQ | sdaOutQ) & hostOeN;  // Pulled-up wire
    wire  [19:0] outs = {procPairEn, serialRefEn, displayEn, panelEn, refEn, refSlewQ, feedbackDivQ};
    clock_output_control_regs dut (.clk(clk), .rstn(rstn), .ce(ce), .sclIn(scl), .sdaIn(sda),
        .sdaOutQ(sdaOutQ), .sdaOeNQ(sdaOeNQ), .procHaltN(procHaltN), .procPairEn(procPairEn),
        .serialRefEn(serialRefEn), .displayEn(displayEn), .panelEn(panelEn), .refEn(refEn),
        .refSlewQ(refSlewQ), .feedbackDivQ(feedbackDivQ));
    smbus_host_model host (.clk(clk), .sda(sda), .scl(scl), .sdaOeN(hostOeN));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [19:0] s, input logic [19:0] e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_sim();
        if (mismatches == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Expected pin outputs from bytes and stop input
    function automatic logic [19:0] expOut();
        logic [2:0] stp;
        stp = procHaltN ? 3'h0 : {bank[3][0], bank[3][1], bank[3][2]};
        return {{bank[2][5], bank[2][6], bank[2][7]} & ~stp, bank[2][2], bank[2][3], bank[2][4],
                bank[2][1:0], bank[3][5:3], bank[4][0], bank[5]};
    endfunction
    // Byte after a host write
    function automatic logic [7:0] nextByte(input logic [7:0] a, old, d);
        case (a)
            8'h02, 8'h05: return d;
            8'h03: return {old[7:6], d[5], (d[4:3] == 2'h3) ? old[4:3] : d[4:3], d[2:0]};
            8'h04: return {old[7:1], d[0]};
            default: return old;
        endcase
    endfunction
    task automatic resetBank();
        bank = '{8'hFF, 8'h30, 8'hCC, 8'h64, 8'hC1, 8'h00, 8'h00};
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("outputs", outs, expOut());
    endtask
    task automatic wr(input logic [7:0] a, d);
        logic [7:0] q;
        logic       ack;
        host.start();
        host.xfer(8'hD2, 1'b1, q, ack);  // Write address
        chk("write ack", 20'(ack), 20'h0);
        host.xfer(a, 1'b1, q, ack);
        host.xfer(8'h01, 1'b1, q, ack);
        host.xfer(d, 1'b1, q, ack);
        host.stop();
        bank[a] = nextByte(a, bank[a], d);
    endtask
    task automatic rd(input logic [7:0] a);
        logic [7:0] q;
        logic       ack;
        host.start();
        host.xfer(8'hD2, 1'b1, q, ack);
        host.xfer(a, 1'b1, q, ack);
        host.start();
        host.xfer(8'hD3, 1'b1, q, ack);  // Read address
        chk("read ack", 20'(ack), 20'h0);
        host.xfer(8'hFF, 1'b0, q, ack);
        chk("count", 20'(q), 20'h0F);
        host.xfer(8'hFF, 1'b1, q, ack);
        chk("read byte", 20'(q), 20'(bank[a]));
        host.stop();
    endtask
    initial begin
        repeat (90000) @(posedge clk);
        mismatches++;
        end_sim();
    end
    initial begin
        logic [7:0]  a, d, q;
        logic        ack;
        logic [19:0] snap;
        rstn = 1'b0;
        ce = 1'b1;
        procHaltN = 1'b1;
        seed = 32'h0a6c;
        resetBank();
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        settle();
        for (int i = 2; i <= 8; i++) rd(8'(i));
        // Corner writes first, then random ones
        for (int i = 0; i < 22; i++) begin
            a = (i < 5) ? cornerA[i] : 8'h02 + 8'($unsigned($random(seed)) % 7);
            d = (i < 5) ? cornerD[i] : 8'($random(seed));
            @(posedge clk) procHaltN <= 1'($random(seed));
            wr(a, d);
            settle();
            rd(a);
        end
        wr(8'h02, 8'hFF);
        wr(8'h03, 8'h05);
        for (int h = 0; h < 2; h++) begin
            @(posedge clk) procHaltN <= 1'(h);
            settle();
        end
        host.start();
        host.xfer(8'hA4, 1'b1, q, ack);  // Foreign address
        host.stop();
        chk("foreign nack", 20'(ack), 20'h1);
        snap = expOut();
        @(posedge clk) ce <= 1'b0;
        procHaltN <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk) chk("frozen", outs, snap);
        @(posedge clk) ce <= 1'b1;
        settle();
        @(posedge clk) rstn <= 1'b0;
        @(posedge clk) rstn <= 1'b1;
        resetBank();
        settle();
        end_sim();
    end
endmodule
